// >>> inc/dcf_pkg.sv
package dcf_pkg;

  localparam int          DATA_W        = 9;
  localparam int          OFFS_W        = 8;
  localparam int          OFFS_NUM      = 4;
  localparam int          DEPTH_DEFAULT = 256;

  // offset register cycle positions
  localparam logic [1:0]  SEL_EMPTY_LO  = 2'h0;
  localparam logic [1:0]  SEL_EMPTY_HI  = 2'h1;
  localparam logic [1:0]  SEL_FULL_LO   = 2'h2;
  localparam logic [1:0]  SEL_FULL_HI   = 2'h3;
  localparam logic [1:0]  SEL_RST       = 2'h0;

  // offset defaults: n = m = 7
  localparam logic [7:0]  OFFS_LO_RST   = 8'h07;
  localparam logic [7:0]  OFFS_HI_RST   = 8'h00;

  localparam logic [8:0]  RD_DATA_RST   = 9'h000;

  // pins seen from outside the core clock domain
  typedef struct packed {
    logic       wr_clk;
    logic       rd_clk;
    logic       fifo_rst_n;
    logic       wr_en_first_n;
    logic       wr_en_second_or_load;
    logic       rd_en_first_n;
    logic       rd_en_second_n;
    logic       out_enable_n;
    logic [8:0] wr_data;
  } dcf_pins_t;

  localparam dcf_pins_t   PINS_RST      = '0;

  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
  } dcf_flags_t;

  // reset state: empty, not full, almost empty, not almost full
  localparam dcf_flags_t  FLAGS_RST     = '{empty_flag_n        : 1'b0,
                                            full_flag_n         : 1'b1,
                                            almost_empty_flag_n : 1'b0,
                                            almost_full_flag_n  : 1'b1};

endpackage

// >>> src/dcf_channel.sv
`timescale 1ns/1ps
// Operation
// R01 - each channel owns its 9-bit word array, pointers, controls and flags
// R02 - after power-up the user resets the channel before use
// R03 - reset empties the channel and drives the empty flag low
// R04 - flags become valid shortly after reset goes low; clocks may run
// R05 - reset needs a falling edge; no reads or writes while it is low
// R06 - after reset outputs drive low when enabled, released when disabled
// R07 - second-enable/load pin level during reset selects its role
// R08 - two-enable mode writes when first enable low and second high
// R09 - programmable-flag mode uses first write enable alone
// R10 - rising read clock with both read enables low presents next word
// R11 - output enable low drives outputs, high releases them
// R12 - writes ignored when full, reads ignored when empty
// R13 - empty channel holds last validly read word on outputs
// R14 - first word readable the read cycle after empty flag rises
// R15 - full flag release may slip to next write edge on close clocks
// R16 - empty flag release may slip to next read edge on close clocks
// R17 - almost-empty change may slip to next read edge on close clocks
// R18 - almost-full change may slip to next write edge on close clocks
// R19 - load and write enable low cycle writes through four offset bytes
// R20 - raising load resumes normal use; offset pointer keeps its place
// R21 - load and read enables low read the next offset byte out
// R22 - user should not write and read offset registers together
// R23 - almost-empty low at n or fewer words, high at n+1 or more
// R24 - almost-full low at depth minus m words, high above m free
// R25 - both offsets default to seven
// R26 - full flag low when full, write-clock timed, blocks all writes; offset register loads still go through
// R27 - depth is a parameter from 256 to 8192; pointers scale
module dcf_channel
#(
  parameter int DEPTH = dcf_pkg::DEPTH_DEFAULT
)
(
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire dcf_pkg::dcf_pins_t   pins,
  output      dcf_pkg::dcf_flags_t  flags,
  output      logic [8:0]           rd_data,
  output      logic                 rd_data_oe_n
);
  import dcf_pkg::*;

  localparam int          AW      = $clog2(DEPTH);
  localparam logic [16:0] DEPTH_C = 17'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and agreement filter

  dcf_pins_t sync1_reg;
  dcf_pins_t sync2_reg;
  dcf_pins_t sync3_reg;
  dcf_pins_t filt_reg;
  dcf_pins_t filt_next;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_reg <= PINS_RST;
      sync2_reg <= PINS_RST;
      sync3_reg <= PINS_RST;
    end
    else if (clk_en)
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // a bit moves only when the second and third stages agree
  always_comb
  begin
    filt_next = dcf_pins_t'((~(sync2_reg ^ sync3_reg) & sync3_reg)
                          | ((sync2_reg ^ sync3_reg) & filt_reg));
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      filt_reg <= PINS_RST;
    else if (clk_en)
      filt_reg <= filt_next;
  end

  logic wr_rise;
  logic rd_rise;
  logic ch_rst;

  assign wr_rise = filt_next.wr_clk & ~filt_reg.wr_clk;
  assign rd_rise = filt_next.rd_clk & ~filt_reg.rd_clk;
  assign ch_rst  = srst | ~filt_reg.fifo_rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // mode capture

  logic load_mode_reg;

  // pin level held through reset picks the role; caught by a clocked process
  always_ff @(posedge core_clk)
  begin
    if (srst)
      load_mode_reg <= 1'b0;
    else if (clk_en && !filt_reg.fifo_rst_n)
      load_mode_reg <= ~filt_reg.wr_en_second_or_load; // R07
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  logic ld_low;
  logic rd_both;
  logic wr_fifo;
  logic wr_offs;
  logic rd_fifo;
  logic rd_offs;

  assign ld_low  = load_mode_reg & ~filt_reg.wr_en_second_or_load;
  assign rd_both = ~filt_reg.rd_en_first_n & ~filt_reg.rd_en_second_n;

  // full flag blocks word writes whatever the enables say; offset loads are not gated by it
  assign wr_fifo = wr_rise & ~filt_reg.wr_en_first_n & flags.full_flag_n // R12 R26
                 & (load_mode_reg ? filt_reg.wr_en_second_or_load       // R09
                                  : filt_reg.wr_en_second_or_load);     // R08
  assign wr_offs = wr_rise & ~filt_reg.wr_en_first_n & ld_low;          // R19
  assign rd_fifo = rd_rise & rd_both & ~ld_low & flags.empty_flag_n;    // R10 R12
  assign rd_offs = rd_rise & rd_both & ld_low;                          // R21

  ////////////////////////////////////////////////////////////////////////////
  // word storage and pointers

  logic [8:0]  mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_next;
  logic [AW:0] fill_next;

  assign wr_ptr_next = wr_fifo ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
  assign rd_ptr_next = rd_fifo ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign fill_next   = wr_ptr_next - rd_ptr_next;

  // storage is not cleared by reset; the pointers define what is valid
  always_ff @(posedge core_clk)
  begin
    if (clk_en && wr_fifo)
      mem_reg[wr_ptr_reg[AW-1:0]] <= filt_reg.wr_data; // R01
  end

  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
    begin
      wr_ptr_reg <= '0; // R03
      rd_ptr_reg <= '0;
    end
    else if (clk_en)
    begin
      wr_ptr_reg <= wr_ptr_next; // R27
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset registers

  logic [7:0]  offs_reg [OFFS_NUM];
  logic [1:0]  offs_sel_reg;
  logic [15:0] empty_offs;
  logic [15:0] full_offs;

  assign empty_offs = {offs_reg[SEL_EMPTY_HI], offs_reg[SEL_EMPTY_LO]};
  assign full_offs  = {offs_reg[SEL_FULL_HI], offs_reg[SEL_FULL_LO]};

  for (genvar i = 0; i < OFFS_NUM; i++)
  begin : g_offs
    localparam logic [7:0] RST_V = (i[0] == 1'b0) ? OFFS_LO_RST : OFFS_HI_RST;
    always_ff @(posedge core_clk)
    begin
      if (ch_rst)
        offs_reg[i] <= RST_V; // R25
      else if (clk_en && wr_offs && offs_sel_reg == 2'(i))
        offs_reg[i] <= filt_reg.wr_data[7:0]; // R19
    end
  end

  // one pointer serves both loading and reading back; it survives load high
  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
      offs_sel_reg <= SEL_RST;
    else if (clk_en && (wr_offs || rd_offs))
      offs_sel_reg <= offs_sel_reg + 2'h1; // R19 R20 R21
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags

  logic        empty_n_reg;
  logic        full_n_reg;
  logic        almost_empty_n_reg;
  logic        almost_full_n_reg;
  logic [16:0] fill_w;
  assign fill_w = 17'(fill_next);

  // edge flags use the state after this edge's own transfer; the other
  // side's change is seen only at this flag's next own-clock edge, which is the deferral
  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
      empty_n_reg <= FLAGS_RST.empty_flag_n; // R03 R04
    else if (clk_en && rd_rise)
      empty_n_reg <= (fill_w != 17'h00000); // R14 R16
  end

  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
      full_n_reg <= FLAGS_RST.full_flag_n; // R04
    else if (clk_en && wr_rise)
      full_n_reg <= (fill_w != DEPTH_C); // R15 R26
  end

  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
      almost_empty_n_reg <= FLAGS_RST.almost_empty_flag_n; // R04
    else if (clk_en && rd_rise)
      almost_empty_n_reg <= (fill_w > {1'b0, empty_offs}); // R17 R23
  end

  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
      almost_full_n_reg <= FLAGS_RST.almost_full_flag_n; // R04
    else if (clk_en && wr_rise)
      almost_full_n_reg <= ((fill_w + {1'b0, full_offs}) < DEPTH_C); // R18 R24
  end

  // one flip-flop per flag, each owned by its own process
  assign flags = '{empty_flag_n        : empty_n_reg,
                   full_flag_n         : full_n_reg,
                   almost_empty_flag_n : almost_empty_n_reg,
                   almost_full_flag_n  : almost_full_n_reg};

  ////////////////////////////////////////////////////////////////////////////
  // output register and drive

  always_ff @(posedge core_clk)
  begin
    if (ch_rst)
      rd_data <= RD_DATA_RST; // R06
    else if (clk_en && rd_fifo)
      rd_data <= mem_reg[rd_ptr_reg[AW-1:0]]; // R10 R13
    else if (clk_en && rd_offs)
      rd_data <= {1'b0, offs_reg[offs_sel_reg]}; // R21
  end

  // low enable means the pins are driven
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rd_data_oe_n <= 1'b1;
    else if (clk_en)
      rd_data_oe_n <= filt_next.out_enable_n; // R06 R11
  end

endmodule // dcf_channel

// >>> tb/dcf_channel_properties.sv
`timescale 1ns/1ps
module dcf_channel_properties
(
  input wire logic                core_clk,
  input wire logic                srst,
  input wire logic                clk_en,
  input wire dcf_pkg::dcf_pins_t  pins,
  input wire dcf_pkg::dcf_flags_t flags,
  input wire logic [8:0]          rd_data,
  input wire logic                rd_data_oe_n
);
  import dcf_pkg::*;
  logic [3:0] wr_age_reg;
  logic [3:0] rd_age_reg;
  // cycles since each pin clock was last high, saturating
  always_ff @(posedge core_clk)
    if (srst)
      wr_age_reg <= 4'hf;
    else
      wr_age_reg <= pins.wr_clk ? 4'h0 : wr_age_reg + {3'h0, ~&wr_age_reg};
  always_ff @(posedge core_clk)
    if (srst)
      rd_age_reg <= 4'hf;
    else
      rd_age_reg <= pins.rd_clk ? 4'h0 : rd_age_reg + {3'h0, ~&rd_age_reg};
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || !pins.fifo_rst_n);
  ////////////////////////////////////////
  a_rst_flags: assert property (disable iff (srst)
    !pins.fifo_rst_n [*6] |-> flags == FLAGS_RST && rd_data == RD_DATA_RST)
    else $error("reset values missing");
  a_full_wrclk: assert property (
    $changed(flags.full_flag_n) |-> wr_age_reg < 4'h6)
    else $error("full flag moved off write clock");
  a_empty_rdclk: assert property (
    $changed(flags.empty_flag_n) |-> rd_age_reg < 4'h6)
    else $error("empty flag moved off read clock");
  a_ae_rdclk: assert property (
    $changed(flags.almost_empty_flag_n) |-> rd_age_reg < 4'h6)
    else $error("almost empty moved off read clock");
  a_af_wrclk: assert property (
    $changed(flags.almost_full_flag_n) |-> wr_age_reg < 4'h6)
    else $error("almost full moved off write clock");
  a_full_af: assert property (
    !flags.full_flag_n |-> !flags.almost_full_flag_n)
    else $error("full without almost full");
  a_oe_drive: assert property (
    !pins.out_enable_n [*6] |-> !rd_data_oe_n)
    else $error("outputs not driven");
  a_rd_hold: assert property (
    !flags.empty_flag_n && pins.wr_en_second_or_load |=> $stable(rd_data))
    else $error("data moved while empty");
endmodule // dcf_channel_properties

bind dcf_channel dcf_channel_properties u_props
(
  .core_clk     (core_clk),
  .srst         (srst),
  .clk_en       (clk_en),
  .pins         (pins),
  .flags        (flags),
  .rd_data      (rd_data),
  .rd_data_oe_n (rd_data_oe_n)
);

// >>> tb/dcf_pin_model.sv
`timescale 1ns/1ps
module dcf_pin_model
(
  input  wire logic          core_clk,
  output dcf_pkg::dcf_pins_t pins
);
  import dcf_pkg::*;
  // idle: enables off, load high, reset high, outputs enabled
  initial pins = 17'h07c00;
  task automatic rst(input logic mode);
    @(posedge core_clk);
    pins.wr_en_second_or_load <= mode;
    pins.fifo_rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    pins.fifo_rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    pins.wr_en_second_or_load <= 1'b1;
  endtask
  // one transfer at a time, so offsets are never written and read together
  task automatic op(input logic wr, input logic ld, input logic [8:0] d);
    @(posedge core_clk);
    pins.wr_en_second_or_load <= ld;
    pins.wr_data <= d;
    pins.wr_en_first_n <= !wr;
    {pins.rd_en_first_n, pins.rd_en_second_n} <= {2{wr}};
    repeat (4) @(posedge core_clk);
    {pins.wr_clk, pins.rd_clk} <= {wr, !wr};
    repeat (4) @(posedge core_clk);
    {pins.wr_clk, pins.rd_clk} <= 2'b00;
    repeat (4) @(posedge core_clk);
    pins.wr_en_first_n <= 1'b1;
    {pins.rd_en_first_n, pins.rd_en_second_n} <= 2'b11;
    pins.wr_en_second_or_load <= 1'b1;
    pins.wr_data <= ~d;
  endtask
  task automatic set_oe(input logic v);
    @(posedge core_clk);
    pins.out_enable_n <= v;
    repeat (6) @(posedge core_clk);
  endtask
endmodule // dcf_pin_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dcf_pkg::*;
  localparam int DEPTH = 256;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_en = 1'b1;
  dcf_pins_t   pins;
  dcf_flags_t  flags;
  logic [8:0]  rd_data;
  logic        rd_data_oe_n;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          i;
  logic [31:0] lfsr = 32'h56a5;
  logic [8:0]  q[$];
  logic [8:0]  last;
  logic [7:0]  offs[4];
  logic [1:0]  ptr;
  logic        pm, em_e, fu_e, ae_e, af_e;
  always #5 core_clk = ~core_clk;
  dcf_pin_model u_pins (.core_clk(core_clk), .pins(pins));
  dcf_channel #(.DEPTH(DEPTH)) dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .pins(pins), .flags(flags), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));
  ////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic reset_chan(input logic mode);
    u_pins.rst(mode);
    pm = !mode;
    q.delete();
    {em_e, fu_e, ae_e, af_e} = FLAGS_RST;
    offs = '{OFFS_LO_RST, OFFS_HI_RST, OFFS_LO_RST, OFFS_HI_RST};
    ptr = 2'h0;
    last = RD_DATA_RST;
    check({5'h0, flags}, {5'h0, FLAGS_RST});
  endtask
  task automatic op(input logic wr, input logic ld);
    logic [8:0] d;
    logic       ok;
    lfsr = nxt(lfsr);
    d = (pm && !ld) ? (ptr[0] ? 9'h000 : {5'h0, lfsr[3:0]}) : lfsr[8:0];
    ok = wr ? fu_e : em_e;
    u_pins.op(wr, ld, d);
    if (pm && !ld)
    begin
      if (wr)
        offs[ptr] = d[7:0];
      else
        last = {1'b0, offs[ptr]};
      ptr = ptr + 2'h1;
    end
    else
    begin
      if (wr && ok && ld)
        q.push_back(d);
      if (!wr && ok)
        last = q.pop_front();
      if (wr)
        {fu_e, af_e} = {q.size() < DEPTH, q.size() + {offs[3], offs[2]} < DEPTH};
      else
        {em_e, ae_e} = {q.size() > 0, q.size() > {offs[1], offs[0]}};
      check({5'h0, flags}, {5'h0, em_e, fu_e, ae_e, af_e});
    end
    check(rd_data, last);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    reset_chan(1'b0);
    // read defaults, write four offsets, read them back
    for (i = 0; i < 12; i++)
      op(i[2], 1'b0);
    repeat (DEPTH + 2) op(1'b1, 1'b1);
    repeat (3) op(1'b0, 1'b1);
    repeat (400) op(lfsr[0], 1'b1);
    repeat (DEPTH + 2) op(1'b0, 1'b1);
    reset_chan(1'b1);
    op(1'b1, 1'b0);
    op(1'b1, 1'b1);
    op(1'b0, 1'b1);
    op(1'b0, 1'b1);
    // a write pulse while the clock enable is low must be lost entirely
    clk_en <= 1'b0;
    u_pins.op(1'b1, 1'b1, 9'h0a5);
    clk_en <= 1'b1;
    op(1'b0, 1'b1);
    u_pins.set_oe(1'b1);
    check({8'h0, rd_data_oe_n}, 9'h001);
    u_pins.set_oe(1'b0);
    check({8'h0, rd_data_oe_n}, 9'h000);
    finish_test();
  end
endmodule // tb_top
